// [src/ref_prediv.v]
// reference input pre-dividers, priority selection and APB register file
//
// Function
// R1: each reference input keeps one priority bit, zero first and one second.
// R2: among equal priority the lowest numbered input wins.
// R3: with skip clear, a cleared hold bit keeps that divider in its reset state; reset is one.
// R4: a zero disable bit enables the divider, a one disables it; reset zero.
// R5: with the skip bit set the reference passes undivided; reset is one.
// R6: with the skip bit clear the reference is divided by the 20-bit count.
// R7: software clears skip whenever the reference is above 33 MHz.
// R8: software programs a count of at least 2 and uses skip to divide by one.
// R9: software keeps the divided rate at most 33 MHz, equal to feedback rate.
// R10: held or disabled dividers with skip clear stay static and restart cleanly on release.
`timescale 1ns/100ps
`default_nettype none
`include "ref_prediv_defines.vh"

module ref_prediv (
    // clock and reset
    input  wire                     mclk,
    input  wire                     rstn,
    // apb slave
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [7:0]               paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    // reference inputs from pins
    input  wire [`NUM_REFS-1:0]     ref_in,
    // to the dpll and clock monitor
    output reg  [`NUM_REFS-1:0]     ref_div_out,
    output reg  [1:0]               preferred_ref,
    output reg                      preferred_valid
);

    wire [32*`NUM_REFS-1:0] setup_flat;
    wire [`NUM_REFS-1:0]  prio;
    wire [`NUM_REFS-1:0]  div_q;
    wire [`NUM_REFS-1:0]  rise;
    wire [`NUM_REFS-1:0]  active;
    wire                  acc;
    wire [1:0]            idx;
    wire                  hit_setup;
    wire                  hit_status;
    reg  [1:0]            sel_next;
    reg                   valid_next;
    integer               k;

    assign acc        = psel & penable & ~pready;
    assign idx        = paddr[3:2];
    assign hit_setup  = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
    assign hit_status = (paddr == `STATUS_ADDR);

    genvar g;
    generate
        for (g = 0; g < `NUM_REFS; g = g + 1) begin : chan
            reg        s1_reg;
            reg        s2_reg;
            reg        s3_reg;
            reg        lvl_reg;
            reg [31:0] setup_reg;

            // three-stage synchroniser, change counts when 2 and 3 agree
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= ref_in[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg)
                        lvl_reg <= s3_reg;
                end
            end
            assign rise[g] = (s2_reg == s3_reg) & s3_reg & ~lvl_reg;

            // R1 R3 R4 R5 per-input setup register
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    setup_reg <= `SETUP_RESET;
                end else if (acc && pwrite && hit_setup && idx == g) begin
                    setup_reg <= pwdata & `SETUP_WMASK;
                end
            end
            // one writer per word keeps each register single-driven
            assign setup_flat[32*g+31:32*g] = setup_reg;
            assign prio[g] = setup_reg[`PRIO_BIT];

            // a divider that is held or disabled is not a candidate
            assign active[g] = setup_reg[`HOLDN_BIT] & ~setup_reg[`DISN_BIT];

            ref_divider ref_divider_i (
                .mclk          (mclk),
                .rstn          (rstn),
                .ref_rise      (rise[g]),
                .ref_level     (lvl_reg),
                .hold_n        (setup_reg[`HOLDN_BIT]),
                .disable_n_bit (setup_reg[`DISN_BIT]),
                .divider_skip  (setup_reg[`SKIP_BIT]),
                .divide_count  (setup_reg[`COUNT_MSB:0]),
                .div_out_reg   (div_q[g])
            );
        end
    endgenerate

    // R2 lowest index wins within a level
    always @* begin
        sel_next   = 2'h0;
        valid_next = 1'b0;
        for (k = `NUM_REFS - 1; k >= 0; k = k - 1) begin
            if (active[k] && !prio[k]) begin
                sel_next   = k[1:0];
                valid_next = 1'b1;
            end
        end
        if (!valid_next) begin
            for (k = `NUM_REFS - 1; k >= 0; k = k - 1) begin
                if (active[k]) begin
                    sel_next   = k[1:0];
                    valid_next = 1'b1;
                end
            end
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ref_div_out     <= {`NUM_REFS{1'b0}};
            preferred_ref   <= 2'h0;
            preferred_valid <= 1'b0;
        end else begin
            ref_div_out     <= div_q;
            preferred_ref   <= sel_next;
            preferred_valid <= valid_next;
        end
    end

    // apb: one wait state, answer in the second access cycle
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (acc) begin
            pready  <= 1'b1;
            pslverr <= ~(hit_setup | hit_status);
            if (pwrite || !(hit_setup | hit_status))
                prdata <= 32'h00000000;
            else if (hit_setup)
                prdata <= setup_flat[32*idx +: 32];
            else
                prdata <= {24'h000000, 1'b0, preferred_valid,
                           preferred_ref, div_q};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // ref_prediv
`default_nettype wire

// [src/ref_prediv_defines.vh]
// register offsets, field positions and reset values of the reference pre-divider
`ifndef REF_PREDIV_DEFINES_VH
`define REF_PREDIV_DEFINES_VH

`define NUM_REFS          4
`define SETUP_STRIDE      8'h04
`define SETUP_BASE        8'h00
`define STATUS_ADDR       8'h10
`define PRIO_BIT          24
`define HOLDN_BIT         22
`define DISN_BIT          21
`define SKIP_BIT          20
`define COUNT_MSB         19
`define SETUP_RESET       32'h00500000
`define SETUP_WMASK       32'h017FFFFF
`define COUNT_W           20

`endif

// [src/ref_divider.v]
// one reference input divider with hold, enable and skip controls
`timescale 1ns/100ps
`default_nettype none
`include "ref_prediv_defines.vh"

module ref_divider (
    // clock and reset
    input  wire                    mclk,
    input  wire                    rstn,
    // reference pulse from the synchroniser
    input  wire                    ref_rise,
    input  wire                    ref_level,
    // controls
    input  wire                    hold_n,
    input  wire                    disable_n_bit,
    input  wire                    divider_skip,
    input  wire [`COUNT_W-1:0]     divide_count,
    // divided clock
    output reg                     div_out_reg
);

    reg  [`COUNT_W-1:0] cnt_reg;
    wire                run;
    wire [`COUNT_W-1:0] half;

    // R3 R4 hold and enable
    assign run  = hold_n & ~disable_n_bit;
    assign half = divide_count >> 1;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg     <= {`COUNT_W{1'b0}};
            div_out_reg <= 1'b0;
        end else if (divider_skip) begin
            // R5 pass reference through
            cnt_reg     <= {`COUNT_W{1'b0}};
            div_out_reg <= ref_level;
        end else if (!run) begin
            // R10 static output, restart state
            cnt_reg     <= {`COUNT_W{1'b0}};
            div_out_reg <= 1'b0;
        end else if (ref_rise) begin
            // R6 divide by the ratio field
            if (cnt_reg + 20'h00001 >= divide_count) begin
                cnt_reg     <= {`COUNT_W{1'b0}};
                div_out_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 20'h00001;
                // R6 one period per ratio cycles
                if (cnt_reg + 20'h00001 >= half)
                    div_out_reg <= 1'b0;
            end
        end
    end

endmodule // ref_divider
`default_nettype wire

// [bench/ref_source.sv]
// reference clock sources with rise counters
`timescale 1ns/100ps
`default_nettype none
module ref_source (
    // clock
    input  wire logic       mclk,
    // reference pins and divided returns
    output var  logic [3:0] ref_in,
    input  wire logic [3:0] ref_div_out
);
    int t[4], rin[4], rout[4];
    logic [3:0] last = 4'h0;
    initial ref_in = 4'h0;
    // all sources far below 33 MHz, so skip is legal
    // divided rates stay under 33 MHz as well
    always @(posedge mclk) begin
        last <= ref_div_out;
        for (int n = 0; n < 4; n++) begin
            t[n] <= (t[n] == n + 1) ? 0 : t[n] + 1;
            if (t[n] == n + 1)
                ref_in[n] <= ~ref_in[n];
            rin[n] <= rin[n] + int'(t[n] == n + 1 && !ref_in[n]);
            rout[n] <= rout[n] + int'(ref_div_out[n] && !last[n]);
        end
    end
endmodule // ref_source
`default_nettype wire

// [bench/ref_prediv_properties.sv]
// apb and divider checks on the pre-divider ports
`timescale 1ns/100ps
`default_nettype none
module ref_prediv_properties (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // references
    input wire logic [3:0]  ref_in,
    input wire logic [3:0]  ref_div_out
);
    logic [31:0] s0;
    wire stop0 = !s0[20] && (!s0[22] || s0[21]);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // shadow input 0 on the edge the slave takes the write
    always @(posedge mclk or negedge rstn)
        if (!rstn)
            s0 <= 32'h00500000;
        else if (psel && penable && !pready && pwrite && paddr == 8'h00)
            s0 <= pwdata & 32'h017FFFFF;
    a_ready_next: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready unasked");
    a_err_map: assert property (pready |-> pslverr ==
        !(paddr == 8'h10 || (paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0)))
        else $error("pslverr wrong");
    a_err_zero: assert property (pslverr |-> !prdata) else $error("data");
    a_rsvd_zero: assert property (pready && !pwrite && paddr < 8'h10
        |-> !prdata[31:25] && !prdata[23]) else $error("reserved set");
    a_held_static:
        assert property (stop0 [*3] |-> !ref_div_out[0]) else $error("moves");
    a_skip_follow:
        assert property (s0[20] [*8]
            |=> ref_div_out[0] == $past(ref_in[0], 6)) else $error("skip");
    c_refused: cover property (pslverr);
    c_held: cover property (stop0 [*8]);
    c_skip: cover property (s0[20] && $rose(ref_div_out[0]));
endmodule // ref_prediv_properties
bind ref_prediv ref_prediv_properties ref_prediv_properties_i (.*);
`default_nettype wire

// [bench/ref_prediv_tb_top.sv]
// self-checking bench for the reference pre-divider
`timescale 1ns/100ps
`default_nettype none
module ref_prediv_tb_top;
    logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err, preferred_valid;
    logic [7:0]  paddr = 8'h00, pa[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h0C};
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [31:0] pd[5] = '{32'h01500000, 32'h00700000, 32'h01500000,
                           32'h00500000, 32'h01500000};
    logic [2:0]  pe[5] = '{3'h5, 3'h6, 3'h4, 3'h7, 3'h4};
    logic [3:0]  ref_in, ref_div_out;
    logic [1:0]  preferred_ref;
    int          errors = 0, check_count = 0, a, b;
    always #25 mclk = ~mclk;
    ref_source ref_source_i (.*);
    ref_prediv ref_prediv_i (.*);
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                @(posedge mclk);
                return;
            end
        end
        errors++;
        final_report;
    endtask
    // k rises in per divided rise; k of zero means static
    task automatic ratio(input int n, input logic [31:0] cfg, input int k);
        apb(1, 8'(4 * n), cfg);
        repeat (40) @(posedge mclk);
        a = ref_source_i.rin[n];
        b = ref_source_i.rout[n];
        repeat (480) @(posedge mclk);
        a = ref_source_i.rin[n] - a;
        b = ref_source_i.rout[n] - b;
        check("div rises", k ? 32'(b * k + k >= a && b * k <= a + k) : b, k > 0);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(0, 8'h00, 0);
        check("setup reset", rd, 32'h00500000);
        apb(1, 8'h0C, 32'hFFFFFFFF);
        apb(0, 8'h0C, 0);
        check("setup mask", rd, 32'h017FFFFF);
        apb(0, 8'h20, 0);
        check("refused data", rd, 0);
        check("refused err", err, 1);
        $display("test registers done");
        foreach (pa[i]) begin
            apb(1, pa[i], pd[i]);
            repeat (4) @(posedge mclk);
            apb(0, 8'h10, 0);
            check("preferred", rd[6:4], pe[i]);
            check("pins", {preferred_valid, preferred_ref}, pe[i]);
        end
        $display("test priority done");
        ratio(2, 32'h00500000, 1);
        ratio(2, 32'h00400002, 2);
        ratio(2, 32'h00400005, 5);
        ratio(2, 32'h00000005, 0);
        ratio(2, 32'h00600005, 0);
        ratio(2, 32'h00400003, 3);
        ratio(0, 32'h00000003, 0);
        $display("test divider done");
        apb(1, 8'h08, 32'h00000000);
        apb(1, 8'h0C, 32'h00600000);
        repeat (4) @(posedge mclk);
        check("none active", {preferred_valid, preferred_ref}, 0);
        $display("test no candidate done");
        final_report;
    end
endmodule // ref_prediv_tb_top
`default_nettype wire
